//--- shared/ser_params.svh
// offsets, field positions and reset values for the status reporting block
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH

`define SER_REG_W        16
`define SER_STB_W        8

`define SER_OP_READ      2'h0
`define SER_OP_WRITE     2'h1
`define SER_OP_PRESET    2'h2

`define SER_NODE_OPER    1'h0
`define SER_NODE_ERR     1'h1

`define SER_SEL_COND     3'h0
`define SER_SEL_RISE     3'h1
`define SER_SEL_FALL     3'h2
`define SER_SEL_EVENT    3'h3
`define SER_SEL_ENABLE   3'h4

`define SER_OP_EXCESS    8
`define SER_OP_INIT      9
`define SER_ERR_CC       7
`define SER_ERR_TEMP     9
`define SER_ERR_PROT     10

`define SER_STB_OPER     7
`define SER_STB_ERR      3

`define SER_FILTER_RST   16'h0000
`define SER_ENABLE_RST   16'h0000
`define SER_EVENT_RST    16'h0000
`define SER_RISE_PRESET  16'hFFFF
`define SER_FALL_PRESET  16'h0000
`define SER_ENABLE_PRESET 16'h0000

`endif

//--- shared/ser_pkg.sv
// types for the status reporting block
`include "ser_params.svh"
package ser_pkg;
	typedef enum logic [1:0] {
		SER_READ   = `SER_OP_READ,
		SER_WRITE  = `SER_OP_WRITE,
		SER_PRESET = `SER_OP_PRESET
	} ser_op_t;

	typedef enum logic [2:0] {
		SER_COND   = `SER_SEL_COND,
		SER_RISE   = `SER_SEL_RISE,
		SER_FALL   = `SER_SEL_FALL,
		SER_EVENT  = `SER_SEL_EVENT,
		SER_ENABLE = `SER_SEL_ENABLE
	} ser_sel_t;

	typedef struct packed {
		ser_op_t                 op;
		logic                    node;
		ser_sel_t                sel;
		logic [`SER_REG_W-1:0]   data;
	} ser_cmd_t;
endpackage

//--- hw/ser_status_node.sv
// one status node: condition, transition filters, event and enable
`timescale 1ns/1ps
`include "ser_params.svh"
module ser_status_node #(
	parameter int W = `SER_REG_W
) (
	input  wire logic         core_clk,  // 200 MHz clock
	input  wire logic         arst_n,    // async reset, low
	input  wire logic [W-1:0] liveCond,  // live state bits
	input  wire logic         wrRise,    // write rise filter
	input  wire logic         wrFall,    // write fall filter
	input  wire logic         wrEnable,  // write enable mask
	input  wire logic [W-1:0] wrData,    // write value
	input  wire logic         preset,    // status preset
	input  wire logic         rdEvent,   // event read, clears
	output logic      [W-1:0] cond,      // condition register
	output logic      [W-1:0] rise,      // rise filter
	output logic      [W-1:0] fall,      // fall filter
	output logic      [W-1:0] event_o,   // event register
	output logic      [W-1:0] enable,    // enable register
	output logic              summary    // summary bit
);
	logic [W-1:0] cond_q;
	logic [W-1:0] rise_q;
	logic [W-1:0] fall_q;
	logic [W-1:0] event_q;
	logic [W-1:0] enable_q;
	logic         summary_q;
	logic [W-1:0] riseHit;
	logic [W-1:0] fallHit;
	logic [W-1:0] setBits;
	logic         anyHit;
	logic         touched_q;

	assign riseHit = liveCond & ~cond_q & rise_q;
	assign fallHit = ~liveCond & cond_q & fall_q;
	assign setBits = riseHit | fallHit;
	assign anyHit  = |(event_q & enable_q);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) cond_q <= W'(0);
		else cond_q <= liveCond;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rise_q <= W'(`SER_FILTER_RST);
			fall_q <= W'(`SER_FILTER_RST);
		end else if (preset) begin
			rise_q <= W'(`SER_RISE_PRESET);
			fall_q <= W'(`SER_FALL_PRESET);
		end else begin
			if (wrRise) rise_q <= wrData;
			if (wrFall) fall_q <= wrData;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) enable_q <= W'(`SER_ENABLE_RST);
		else if (preset) enable_q <= W'(`SER_ENABLE_PRESET);
		else if (wrEnable) enable_q <= wrData;
	end

	// new edges win over the read clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) event_q <= W'(`SER_EVENT_RST);
		else event_q <= (rdEvent ? W'(0) : event_q) | setBits;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) summary_q <= 1'b0;
		else summary_q <= anyHit;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) touched_q <= 1'b0;
		else if (preset || wrRise || wrFall) touched_q <= 1'b1;
	end

	assign cond    = cond_q;
	assign rise    = rise_q;
	assign fall    = fall_q;
	assign event_o = event_q;
	assign enable  = enable_q;
	assign summary = summary_q;

	rise_capture_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(|riseHit) |=> ((event_q & $past(riseHit)) == $past(riseHit)))
		else $error("rising edge not latched");

	fall_capture_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(|fallHit) |=> ((event_q & $past(fallHit)) == $past(fallHit)))
		else $error("falling edge not latched");

	filter_powerup_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!touched_q |-> (rise_q == W'(0)) && (fall_q == W'(0)))
		else $error("filter not disabled after power-up");

	event_clear_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		rdEvent |=> event_q == $past(setBits))
		else $error("event register not cleared by read");

	preset_values_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		preset |=> (rise_q == W'(`SER_RISE_PRESET)) && (fall_q == W'(0))
			&& (enable_q == W'(0)))
		else $error("preset left wrong filter or enable value");

	summary_follow_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 summary_q == $past(anyHit))
		else $error("summary not one cycle behind event and enable");
endmodule

//--- hw/ser_status_event_reporting.sv
// status reporting: two status nodes, command port and status byte
`timescale 1ns/1ps
`include "ser_params.svh"
// Functional notes
// - condition register follows live state, read-safe
// - enabled rising condition edge sets event bit
// - enabled falling condition edge sets event bit
// - transition filters start disabled at power-up
// - event read returns bits, then clears
// - enabled operation events drive status bit 7
// - enabled error events drive status bit 3
// - operation bit 8 flags unreachable power
// - operation bit 9 flags initialization running
// - error bit 7 flags coherence power shortfall
// - error bit 9 flags temperature stabilizing
// - error bit 10 flags protective shutdown
// - filter and enable writes read back unchanged
// - preset clears enables, rise ones, fall zero
module ser_status_event_reporting #(
	parameter int W = `SER_REG_W
) (
	input  wire logic              core_clk,       // 200 MHz clock
	input  wire logic              arst_n,         // async reset, low
	input  wire logic              cmdValid,       // command strobe
	input  ser_pkg::ser_cmd_t      cmd,            // command word
	output logic                   rspValid,       // read answer strobe
	output logic         [W-1:0]   rspData,        // read answer data
	input  wire logic              powerOverRange, // set power unreachable
	input  wire logic              ampMismatch,    // output differs from set
	input  wire logic              initBusy,       // power-up init running
	input  wire logic              ccActive,       // coherence control on
	input  wire logic              ccBelowUncal,   // power under cc threshold
	input  wire logic              tempUnstable,   // chamber temp out of range
	input  wire logic              diodeProtect,   // output off for diode
	output logic [`SER_STB_W-1:0]  statusByte      // summary status byte
);
	localparam int NODES = 2;

	logic [W-1:0] liveCond [NODES];
	logic [W-1:0] condArr  [NODES];
	logic [W-1:0] riseArr  [NODES];
	logic [W-1:0] fallArr  [NODES];
	logic [W-1:0] eventArr [NODES];
	logic [W-1:0] enArr    [NODES];
	logic         sumArr   [NODES];
	logic         wrRise   [NODES];
	logic         wrFall   [NODES];
	logic         wrEnable [NODES];
	logic         rdEvent  [NODES];

	logic         isRead;
	logic         isWrite;
	logic         isPreset;
	logic [W-1:0] readView;
	logic         rspValid_q;
	logic [W-1:0] rspData_q;

	assign isRead   = cmdValid && (cmd.op == ser_pkg::SER_READ);
	assign isWrite  = cmdValid && (cmd.op == ser_pkg::SER_WRITE);
	assign isPreset = cmdValid && (cmd.op == ser_pkg::SER_PRESET);

	// live bits of both nodes; a mismatch of amplitude shares the excess bit
	always_comb begin
		liveCond[`SER_NODE_OPER] = W'(0);
		liveCond[`SER_NODE_OPER][`SER_OP_EXCESS] =
			powerOverRange | ampMismatch;
		liveCond[`SER_NODE_OPER][`SER_OP_INIT] = initBusy;
		liveCond[`SER_NODE_ERR] = W'(0);
		liveCond[`SER_NODE_ERR][`SER_ERR_CC] = ccActive & ccBelowUncal;
		liveCond[`SER_NODE_ERR][`SER_ERR_TEMP] = tempUnstable;
		liveCond[`SER_NODE_ERR][`SER_ERR_PROT] = diodeProtect;
	end

	genvar n;
	generate
		for (n = 0; n < NODES; n++) begin : gNode
			logic hit;

			assign hit = (cmd.node == 1'(n));
			// condition and event are not writable
			assign wrRise[n]   = isWrite && hit && (cmd.sel == ser_pkg::SER_RISE);
			assign wrFall[n]   = isWrite && hit && (cmd.sel == ser_pkg::SER_FALL);
			assign wrEnable[n] = isWrite && hit && (cmd.sel == ser_pkg::SER_ENABLE);
			assign rdEvent[n]  = isRead && hit && (cmd.sel == ser_pkg::SER_EVENT);

			ser_status_node #(
				.W (W)
			) uNode (
				.core_clk (core_clk),
				.arst_n   (arst_n),
				.liveCond (liveCond[n]),
				.wrRise   (wrRise[n]),
				.wrFall   (wrFall[n]),
				.wrEnable (wrEnable[n]),
				.wrData   (cmd.data),
				.preset   (isPreset),
				.rdEvent  (rdEvent[n]),
				.cond     (condArr[n]),
				.rise     (riseArr[n]),
				.fall     (fallArr[n]),
				.event_o  (eventArr[n]),
				.enable   (enArr[n]),
				.summary  (sumArr[n])
			);
		end
	endgenerate

	// read selection; reading condition has no side effect
	always_comb begin
		if (cmd.sel == ser_pkg::SER_COND) begin
			readView = condArr[cmd.node];
		end else if (cmd.sel == ser_pkg::SER_RISE) begin
			readView = riseArr[cmd.node];
		end else if (cmd.sel == ser_pkg::SER_FALL) begin
			readView = fallArr[cmd.node];
		end else if (cmd.sel == ser_pkg::SER_EVENT) begin
			readView = eventArr[cmd.node];
		end else if (cmd.sel == ser_pkg::SER_ENABLE) begin
			readView = enArr[cmd.node];
		end else begin
			readView = W'(0);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) rspValid_q <= 1'b0;
		else rspValid_q <= isRead;
	end

	// data held until the next read
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) rspData_q <= W'(0);
		else if (isRead) rspData_q <= readView;
	end

	assign rspValid = rspValid_q;
	assign rspData  = rspData_q;

	always_comb begin
		statusByte = `SER_STB_W'(0);
		statusByte[`SER_STB_OPER] = sumArr[`SER_NODE_OPER];
		statusByte[`SER_STB_ERR]  = sumArr[`SER_NODE_ERR];
	end

	cond_track_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 (condArr[0] == $past(liveCond[0])) && (condArr[1] == $past(liveCond[1])))
		else $error("condition register lags live state");

	excess_power_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		powerOverRange |=> condArr[`SER_NODE_OPER][`SER_OP_EXCESS])
		else $error("excess power not flagged");

	amp_mismatch_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		ampMismatch |=> condArr[`SER_NODE_OPER][`SER_OP_EXCESS])
		else $error("amplitude mismatch not flagged");

	excess_clear_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(!powerOverRange && !ampMismatch) |=> !condArr[`SER_NODE_OPER][`SER_OP_EXCESS])
		else $error("excess power flag stuck");

	init_busy_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 condArr[`SER_NODE_OPER][`SER_OP_INIT] == $past(initBusy))
		else $error("initialization flag wrong");

	cc_shortfall_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 condArr[`SER_NODE_ERR][`SER_ERR_CC] == ($past(ccActive) && $past(ccBelowUncal)))
		else $error("coherence shortfall flag wrong");

	temp_range_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		tempUnstable [*2] |-> condArr[`SER_NODE_ERR][`SER_ERR_TEMP])
		else $error("temperature flag wrong");

	diode_protect_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(diodeProtect) |=> condArr[`SER_NODE_ERR][`SER_ERR_PROT])
		else $error("protective shutdown flag wrong");

	oper_summary_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(|(eventArr[`SER_NODE_OPER] & enArr[`SER_NODE_OPER])) |=> statusByte[`SER_STB_OPER])
		else $error("operation summary bit missing");

	err_summary_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(|(eventArr[`SER_NODE_ERR] & enArr[`SER_NODE_ERR])) |=> statusByte[`SER_STB_ERR])
		else $error("error summary bit missing");

	summary_quiet_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(eventArr[`SER_NODE_OPER] & enArr[`SER_NODE_OPER]) == W'(0)
			|=> !statusByte[`SER_STB_OPER])
		else $error("operation summary without enabled event");

	rise_readback_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		wrRise[`SER_NODE_ERR] |=> riseArr[`SER_NODE_ERR] == $past(cmd.data))
		else $error("rise filter write not kept");

	event_read_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		rdEvent[`SER_NODE_OPER] |=> rspValid && (rspData == $past(eventArr[0])))
		else $error("event read returned wrong bits");

	resp_pulse_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		isRead |=> rspValid)
		else $error("read answer missing");

	resp_quiet_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!isRead |=> !rspValid)
		else $error("answer without a read");

	resp_data_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		isRead |=> rspData == $past(readView))
		else $error("read answer data wrong");

	resp_hold_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!isRead |=> $stable(rspData))
		else $error("read data changed without a read");

	keep_oper_event_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!rdEvent[0] |=> (eventArr[0] & $past(eventArr[0])) == $past(eventArr[0]))
		else $error("operation event lost without event read");

	keep_err_event_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!rdEvent[1] |=> (eventArr[1] & $past(eventArr[1])) == $past(eventArr[1]))
		else $error("error event lost without event read");

	oper_rise_write_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		wrRise[`SER_NODE_OPER] |=> riseArr[`SER_NODE_OPER] == $past(cmd.data))
		else $error("operation rise filter write not kept");

	oper_fall_write_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		wrFall[`SER_NODE_OPER] |=> fallArr[`SER_NODE_OPER] == $past(cmd.data))
		else $error("operation fall filter write not kept");

	err_fall_write_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		wrFall[`SER_NODE_ERR] |=> fallArr[`SER_NODE_ERR] == $past(cmd.data))
		else $error("error fall filter write not kept");

	oper_en_write_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		wrEnable[`SER_NODE_OPER] |=> enArr[`SER_NODE_OPER] == $past(cmd.data))
		else $error("operation enable write not kept");

	err_en_write_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		wrEnable[`SER_NODE_ERR] |=> enArr[`SER_NODE_ERR] == $past(cmd.data))
		else $error("error enable write not kept");

	oper_filter_hold_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!cmdValid |=> $stable(riseArr[0]) && $stable(fallArr[0]))
		else $error("operation filter changed without command");

	err_filter_hold_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!cmdValid |=> $stable(riseArr[1]) && $stable(fallArr[1]))
		else $error("error filter changed without command");

	enable_hold_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		!cmdValid |=> $stable(enArr[0]) && $stable(enArr[1]))
		else $error("enable changed without command");

	preset_enable_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		isPreset |=> (enArr[0] | enArr[1]) == W'(`SER_ENABLE_PRESET))
		else $error("preset left an enable bit set");

	preset_rise_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		isPreset |=> (riseArr[0] & riseArr[1]) == W'(`SER_RISE_PRESET))
		else $error("preset left a rise filter bit clear");

	preset_fall_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		isPreset |=> (fallArr[0] | fallArr[1]) == W'(`SER_FALL_PRESET))
		else $error("preset left a fall filter bit set");

	err_read_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		rdEvent[`SER_NODE_ERR] |=> rspValid && (rspData == $past(eventArr[1])))
		else $error("error event read returned wrong bits");

	oper_read_clear_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(rdEvent[0] && (liveCond[0] == condArr[0])) |=> eventArr[0] == W'(0))
		else $error("operation event not cleared by read");

	err_read_clear_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(rdEvent[1] && (liveCond[1] == condArr[1])) |=> eventArr[1] == W'(0))
		else $error("error event not cleared by read");

	stb_reserved_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(statusByte & 8'h77) == 8'h00)
		else $error("unused status byte bit set");

	err_quiet_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(eventArr[1] & enArr[1]) == W'(0) |=> !statusByte[`SER_STB_ERR])
		else $error("error summary without enabled event");

	unmapped_read_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(isRead && (cmd.sel > ser_pkg::SER_ENABLE)) |=> rspData == W'(0))
		else $error("unmapped read returned nonzero data");

	init_event_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(riseArr[0][`SER_OP_INIT] && initBusy && !condArr[0][`SER_OP_INIT])
			|=> eventArr[0][`SER_OP_INIT])
		else $error("initialization edge not latched");

	prot_event_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(fallArr[1][`SER_ERR_PROT] && !diodeProtect && condArr[1][`SER_ERR_PROT])
			|=> eventArr[1][`SER_ERR_PROT])
		else $error("shutdown end not latched");

	cc_event_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(riseArr[1][`SER_ERR_CC] && ccActive && ccBelowUncal && !condArr[1][`SER_ERR_CC])
			|=> eventArr[1][`SER_ERR_CC])
		else $error("coherence shortfall edge not latched");

	excess_event_a:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(riseArr[0][`SER_OP_EXCESS] && powerOverRange && !condArr[0][`SER_OP_EXCESS])
			|=> eventArr[0][`SER_OP_EXCESS])
		else $error("excess power edge not latched");
endmodule

//--- test/ser_host_model.sv
// host controller model issuing status commands
`timescale 1ns/1ps
module ser_host_model (
	input  wire logic        core_clk, // block clock
	output logic             cmdValid, // command strobe
	output ser_pkg::ser_cmd_t cmd      // command word
);
	initial begin
		cmdValid = 1'b0;
		cmd      = '0;
	end

	// one command per edge, whole word at once
	task automatic issue(input ser_pkg::ser_op_t op, input logic node,
			input ser_pkg::ser_sel_t sel, input logic [15:0] data);
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmd      <= '{op, node, sel, data};
	endtask

	// released word toggles so stale values cannot pass
	task automatic idle();
		@(posedge core_clk);
		cmdValid <= 1'b0;
		cmd      <= ser_pkg::ser_cmd_t'(~cmd);
	endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the status reporting block
`timescale 1ns/1ps
module testbench;
	logic              core_clk;
	logic              arst_n;
	logic              cmdValid;
	ser_pkg::ser_cmd_t cmd;
	logic              rspValid;
	logic [15:0]       rspData;
	logic [6:0]        lv;
	logic [7:0]        statusByte;
	logic [15:0]       expQ[$];
	logic [15:0]       opEv, erEv, opPrev, erPrev, r;
	int                errors, comparisons;

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	ser_host_model host_u (.core_clk(core_clk), .cmdValid(cmdValid), .cmd(cmd));

	ser_status_event_reporting dut_u (
		.core_clk(core_clk), .arst_n(arst_n), .cmdValid(cmdValid), .cmd(cmd),
		.rspValid(rspValid), .rspData(rspData), .powerOverRange(lv[0]),
		.ampMismatch(lv[1]), .initBusy(lv[2]), .ccActive(lv[3]), .ccBelowUncal(lv[4]),
		.tempUnstable(lv[5]), .diodeProtect(lv[6]), .statusByte(statusByte)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic rd(input logic n, input ser_pkg::ser_sel_t s, input logic [15:0] e);
		expQ.push_back(e);
		host_u.issue(ser_pkg::SER_READ, n, s, 16'h0000);
	endtask

	task automatic wr(input logic n, input ser_pkg::ser_sel_t s, input logic [15:0] d);
		host_u.issue(ser_pkg::SER_WRITE, n, s, d);
	endtask

	task automatic gap(input int n);
		host_u.idle();
		repeat (n) @(posedge core_clk);
	endtask

	task automatic live(input logic [6:0] v);
		host_u.idle();
		lv <= v;
	endtask

	function automatic logic [15:0] opCond(input logic [6:0] v);
		return {6'h00, v[2], v[0] | v[1], 8'h00};
	endfunction

	function automatic logic [15:0] erCond(input logic [6:0] v);
		return {5'h00, v[6], v[5], 1'b0, v[3] & v[4], 7'h00};
	endfunction

	// read answers are compared oldest first
	always @(posedge core_clk) begin
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) begin
				errors++;
				$display("[FAIL] %0t answer without a read", $time);
			end else
				check(rspData, expQ.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		$display("[FAIL] %0t run did not finish", $time);
		summarize();
	end

	initial begin
		arst_n = 1'b0;
		lv = 7'h00;
		errors = 0;
		comparisons = 0;
		r = 16'($urandom(32'hBB9C));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int n = 0; n < 2; n++) begin
			rd(n[0], ser_pkg::SER_RISE, 16'h0000);
			rd(n[0], ser_pkg::SER_FALL, 16'h0000);
			rd(n[0], ser_pkg::SER_ENABLE, 16'h0000);
			rd(n[0], ser_pkg::SER_EVENT, 16'h0000);
		end
		gap(2);
		$display("test reset values done");
		for (int n = 0; n < 2; n++) begin
			for (int s = 1; s < 5; s++) begin
				if (s == 3)
					continue;
				r = 16'($urandom());
				wr(n[0], ser_pkg::ser_sel_t'(s[2:0]), r);
				rd(n[0], ser_pkg::ser_sel_t'(s[2:0]), r);
			end
		end
		wr(1'b0, ser_pkg::SER_COND, 16'hFFFF);
		rd(1'b0, ser_pkg::SER_COND, 16'h0000);
		rd(1'b1, ser_pkg::ser_sel_t'(3'h5), 16'h0000);
		gap(2);
		$display("test write readback done");
		host_u.issue(ser_pkg::SER_PRESET, 1'b0, ser_pkg::SER_COND, 16'h0000);
		for (int n = 0; n < 2; n++) begin
			rd(n[0], ser_pkg::SER_RISE, 16'hFFFF);
			rd(n[0], ser_pkg::SER_FALL, 16'h0000);
			rd(n[0], ser_pkg::SER_ENABLE, 16'h0000);
		end
		gap(2);
		$display("test preset done");
		opEv = 16'h0000;
		erEv = 16'h0000;
		for (int i = 0; i < 24; i++) begin
			opPrev = opCond(lv);
			erPrev = erCond(lv);
			live(7'($urandom()));
			gap(2);
			opEv |= opCond(lv) & ~opPrev;
			erEv |= erCond(lv) & ~erPrev;
			rd(1'b0, ser_pkg::SER_COND, opCond(lv));
			rd(1'b0, ser_pkg::SER_COND, opCond(lv));
			rd(1'b1, ser_pkg::SER_COND, erCond(lv));
		end
		live(7'h00);
		gap(3);
		rd(1'b0, ser_pkg::SER_EVENT, opEv);
		rd(1'b1, ser_pkg::SER_EVENT, erEv);
		rd(1'b0, ser_pkg::SER_EVENT, 16'h0000);
		rd(1'b1, ser_pkg::SER_EVENT, 16'h0000);
		gap(2);
		$display("test condition and events done");
		wr(1'b1, ser_pkg::SER_RISE, 16'h0000);
		wr(1'b1, ser_pkg::SER_FALL, 16'h0400);
		wr(1'b1, ser_pkg::SER_ENABLE, 16'h0400);
		wr(1'b0, ser_pkg::SER_ENABLE, 16'h0200);
		live(7'h40);
		gap(3);
		#1 check({8'h00, statusByte}, 16'h0000);
		live(7'h00);
		gap(3);
		#1 check({8'h00, statusByte}, 16'h0008);
		rd(1'b1, ser_pkg::SER_EVENT, 16'h0400);
		gap(3);
		#1 check({8'h00, statusByte}, 16'h0000);
		live(7'h04);
		gap(3);
		#1 check({8'h00, statusByte}, 16'h0080);
		rd(1'b0, ser_pkg::SER_EVENT, 16'h0200);
		gap(3);
		#1 check({8'h00, statusByte}, 16'h0000);
		live(7'h05);
		gap(3);
		#1 check({8'h00, statusByte}, 16'h0000);
		rd(1'b0, ser_pkg::SER_EVENT, 16'h0100);
		gap(2);
		$display("test summary bits done");
		for (int i = 0; i < 20 && expQ.size() != 0; i++)
			@(posedge core_clk);
		if (expQ.size() != 0) begin
			errors++;
			$display("[FAIL] %0t reads left unanswered", $time);
		end
		summarize();
	end
endmodule
